// *** hdl/drpm_top.sv ***
`timescale 1ns/100ps
// Functional notes
// R1: alt1 port A returns 16-bit memory address
// R2: after ecc error, address is next sector
// R3: host ignores address after other errors
// R4: alt1 port B: extended address, high bits zero
// R5: alt2 port A returns remainder high bits
// R6: alt2 port B returns remainder low bits
// R7: remainder held from last read/verify
// R8: port C surface in bits 1-5
// R9: multifunction variant: six-bit surface, bits 0-5
// R10: port C bits 6-10: next sector address
// R11: port C bits 11-15: two's complement count
// R12: normal port B returns drive status flags
// R13: host-written mode selector steers port mux
module drpm_top #(
   parameter bit MULTI_VARIANT    = 1'b0,  // six-bit surface, no xma
   parameter int WORDS_PER_SECTOR = drpm_pkg::WORDS_PER_SECTOR
) (
   input  wire logic        sys_clk,            // 200 mhz clock
   input  wire logic        rstn,               // async reset, active low
   input  wire logic        mode_wr,            // mode selector write
   input  wire logic [1:0]  mode_sel,           // mode selector code
   input  wire logic        input_port_a_instr, // port A read strobe
   input  wire logic        input_port_b_instr, // port B read strobe
   input  wire logic        input_port_c_instr, // port C read strobe
   input  wire logic [15:0] ctrl_status,        // normal port A word
   input  wire logic [15:0] drive_status,       // selected drive flags
   input  wire logic        ma_load,            // memory address write
   input  wire logic [15:0] ma_wdata,           // memory address value
   input  wire logic        xma_load,           // extended address write
   input  wire logic [3:0]  xma_wdata,          // extended address value
   input  wire logic        word_xfer,          // one data channel word
   input  wire logic        sector_done,        // sector finished
   input  wire logic        ecc_err_end,        // transfer ended on ecc
   input  wire logic        chs_load,           // surface/sector/count write
   input  wire logic [5:0]  surf_wdata,         // surface value
   input  wire logic [4:0]  sec_wdata,          // sector value
   input  wire logic [4:0]  cnt_wdata,          // negated sector count
   input  wire logic        ecc_capture,        // read/verify finished
   input  wire logic [31:0] ecc_rem,            // remainder of that pass
   output logic [15:0]      rd_data,            // instruction read data
   output logic             rd_valid,           // read data strobe
   output logic [1:0]       mode                // current mode
);

   if (WORDS_PER_SECTOR < 1 || WORDS_PER_SECTOR > 65535) begin : g_bad
      $error("WORDS_PER_SECTOR out of range");
   end

   localparam logic [15:0] SECTOR_STEP = 16'(WORDS_PER_SECTOR);

   logic rst_meta_q;
   logic rst_n_s;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_n_s    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_s    <= rst_meta_q;
      end
   end

   drpm_ecc_if ecc_bus ();

   assign ecc_bus.capture = ecc_capture;
   assign ecc_bus.rem     = ecc_rem;

   drpm_ecc_hold u_ecc (
      .sys_clk (sys_clk),
      .rst_n   (rst_n_s),
      .ecc     (ecc_bus.keeper)
   );

   // ------------------------------------------------------------ mode
   drpm_pkg::drpm_mode_e mode_q;
   drpm_pkg::drpm_mode_e mode_d;

   always_comb begin
      mode_d = mode_q;
      if (mode_wr) begin
         case (mode_sel)
            drpm_pkg::SEL_NORMAL: mode_d = drpm_pkg::DRPM_NORMAL; // [R13]
            drpm_pkg::SEL_ALT1:   mode_d = drpm_pkg::DRPM_ALT1;   // [R13]
            drpm_pkg::SEL_ALT2:   mode_d = drpm_pkg::DRPM_ALT2;   // [R13]
            default:              mode_d = mode_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         mode_q <= drpm_pkg::DRPM_NORMAL;
      end else begin
         mode_q <= mode_d;
      end
   end

   // ---------------------------------------------- transfer tracking
   logic [15:0] ma_q;
   logic [15:0] ma_d;
   logic [15:0] sec_base_q;
   logic [15:0] sec_base_d;
   logic [3:0]  xma_q;
   logic [3:0]  xma_d;
   logic [5:0]  surf_q;
   logic [5:0]  surf_d;
   logic [4:0]  sec_q;
   logic [4:0]  sec_d;
   logic [4:0]  cnt_q;
   logic [4:0]  cnt_d;

   always_comb begin
      ma_d       = ma_q;
      sec_base_d = sec_base_q;
      xma_d      = xma_q;
      surf_d     = surf_q;
      sec_d      = sec_q;
      cnt_d      = cnt_q;
      if (ma_load) begin
         ma_d = ma_wdata;
      end else if (ecc_err_end) begin
         ma_d = 16'(sec_base_q + SECTOR_STEP); // [R2]
      end else if (word_xfer) begin
         ma_d = 16'(ma_q + 16'h0001); // [R1]
      end
      // start of the current sector, for ecc-error recovery
      if (ma_load || sector_done || ecc_err_end) begin
         sec_base_d = ma_d;
      end
      if (xma_load) begin
         xma_d = xma_wdata;
      end
      if (chs_load) begin
         surf_d = MULTI_VARIANT ? surf_wdata : {1'b0, surf_wdata[4:0]};
         sec_d  = sec_wdata;
         cnt_d  = cnt_wdata;
      end else if (sector_done) begin
         sec_d = 5'(sec_q + 5'h01);     // [R10]
         cnt_d = 5'(cnt_q + 5'h01);     // [R11]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         ma_q       <= drpm_pkg::RST_WORD;
         sec_base_q <= drpm_pkg::RST_WORD;
         xma_q      <= drpm_pkg::RST_XMA;
         surf_q     <= drpm_pkg::RST_SURF;
         sec_q      <= drpm_pkg::RST_FIELD5;
         cnt_q      <= drpm_pkg::RST_FIELD5;
      end else begin
         ma_q       <= ma_d;
         sec_base_q <= sec_base_d;
         xma_q      <= xma_d;
         surf_q     <= surf_d;
         sec_q      <= sec_d;
         cnt_q      <= cnt_d;
      end
   end

   // ------------------------------------------------- word builders
   function automatic logic [15:0] c_word(input logic [5:0] surf,
                                          input logic [4:0] sec,
                                          input logic [4:0] cnt,
                                          input logic       multi);
      logic [15:0] w;
      w = drpm_pkg::RST_WORD;
      if (multi) begin
         w[drpm_pkg::SURF_LSB +: drpm_pkg::SURF_W] = surf;       // [R9]
      end else begin
         w[drpm_pkg::SURF_LSB +: drpm_pkg::SURF_W] = {1'b0, surf[4:0]}; // [R8]
      end
      w[drpm_pkg::SEC_LSB +: drpm_pkg::SEC_W] = sec;             // [R10]
      w[drpm_pkg::CNT_LSB +: drpm_pkg::CNT_W] = cnt;             // [R11]
      return w;
   endfunction : c_word

   function automatic logic [15:0] xma_word(input logic [3:0] x,
                                            input logic       multi);
      logic [15:0] w;
      w = drpm_pkg::RST_WORD;
      if (!multi) begin
         w[drpm_pkg::XMA_LSB +: drpm_pkg::XMA_W] = x; // [R4]
      end
      return w;
   endfunction : xma_word

   // ------------------------------------------------------ read mux
   logic [15:0] rd_data_q;
   logic [15:0] rd_data_d;
   logic        rd_valid_q;
   logic        rd_valid_d;

   always_comb begin
      rd_data_d  = rd_data_q;
      rd_valid_d = 1'b0;
      if (input_port_a_instr) begin
         rd_valid_d = 1'b1;
         case (mode_q)
            drpm_pkg::DRPM_ALT1:   rd_data_d = ma_q;                 // [R1]
            drpm_pkg::DRPM_ALT2:   rd_data_d = ecc_bus.held[31:16];  // [R5]
            default:               rd_data_d = ctrl_status;          // [R13]
         endcase
      end else if (input_port_b_instr) begin
         rd_valid_d = 1'b1;
         case (mode_q)
            drpm_pkg::DRPM_ALT1:
               rd_data_d = xma_word(xma_q, MULTI_VARIANT);           // [R4]
            drpm_pkg::DRPM_ALT2:   rd_data_d = ecc_bus.held[15:0];   // [R6]
            default:               rd_data_d = drive_status;         // [R12]
         endcase
      end else if (input_port_c_instr) begin
         rd_valid_d = 1'b1;
         rd_data_d  = c_word(surf_q, sec_q, cnt_q, MULTI_VARIANT);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         rd_data_q  <= drpm_pkg::RST_WORD;
         rd_valid_q <= 1'b0;
      end else begin
         rd_data_q  <= rd_data_d;
         rd_valid_q <= rd_valid_d;
      end
   end

   assign rd_data  = rd_data_q;
   assign rd_valid = rd_valid_q;
   assign mode     = mode_q;

   // ---------------------------------------------------- assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n_s);

   property p_alt1_a;
      input_port_a_instr && mode_q == drpm_pkg::DRPM_ALT1
         |=> rd_valid && rd_data == $past(ma_q);
   endproperty
   a_alt1_a: assert property (p_alt1_a) // [R1]
      else $error("alt1 port A did not return memory address");

   property p_ecc_ma;
      ecc_err_end && !ma_load
         |=> ma_q == 16'($past(sec_base_q) + SECTOR_STEP);
   endproperty
   a_ecc_ma: assert property (p_ecc_ma) // [R2]
      else $error("address after ecc error not next sector");

   property p_alt1_b;
      input_port_b_instr && !input_port_a_instr
         && mode_q == drpm_pkg::DRPM_ALT1
         |=> rd_data[15:4] == 12'h000
             && rd_data[3:0] == (MULTI_VARIANT ? 4'h0 : $past(xma_q));
   endproperty
   a_alt1_b: assert property (p_alt1_b) // [R4]
      else $error("alt1 port B word wrong");

   property p_alt2_a;
      input_port_a_instr && mode_q == drpm_pkg::DRPM_ALT2
         |=> rd_data == $past(ecc_bus.held[31:16]);
   endproperty
   a_alt2_a: assert property (p_alt2_a) // [R5]
      else $error("alt2 port A not remainder high half");

   property p_alt2_b;
      input_port_b_instr && !input_port_a_instr
         && mode_q == drpm_pkg::DRPM_ALT2
         |=> rd_data == $past(ecc_bus.held[15:0]);
   endproperty
   a_alt2_b: assert property (p_alt2_b) // [R6]
      else $error("alt2 port B not remainder low half");

   property p_c_surf;
      input_port_c_instr && !input_port_a_instr && !input_port_b_instr
         |=> (MULTI_VARIANT || !rd_data[15])
             && rd_data[14:10] == $past(surf_q[4:0]);
   endproperty
   a_c_surf: assert property (p_c_surf) // [R8]
      else $error("port C surface field wrong");

   property p_c_multi;
      input_port_c_instr && !input_port_a_instr && !input_port_b_instr
         && MULTI_VARIANT |=> rd_data[15:10] == $past(surf_q);
   endproperty
   a_c_multi: assert property (p_c_multi) // [R9]
      else $error("six-bit surface field wrong");

   property p_sec_step;
      sector_done && !chs_load ##1 input_port_c_instr
         && !input_port_a_instr && !input_port_b_instr
         |=> rd_data[9:5] == 5'($past(sec_q, 2) + 5'h01)
             && rd_data[4:0] == 5'($past(cnt_q, 2) + 5'h01);
   endproperty
   a_sec_step: assert property (p_sec_step) // [R10] [R11]
      else $error("sector or count did not advance");

   property p_norm_b;
      input_port_b_instr && !input_port_a_instr
         && mode_q == drpm_pkg::DRPM_NORMAL
         |=> rd_data == $past(drive_status);
   endproperty
   a_norm_b: assert property (p_norm_b) // [R12]
      else $error("normal port B not drive status");

   property p_mode_wr;
      mode_wr && mode_sel == drpm_pkg::SEL_ALT2
         |=> mode_q == drpm_pkg::DRPM_ALT2 ##1 1'b1;
   endproperty
   a_mode_wr: assert property (p_mode_wr) // [R13]
      else $error("mode selector write not taken");

   c_alt1_read: cover property (input_port_a_instr
                                && mode_q == drpm_pkg::DRPM_ALT1);
   c_alt2_read: cover property (input_port_b_instr
                                && mode_q == drpm_pkg::DRPM_ALT2);
   c_ecc_end:   cover property (ecc_err_end ##[1:20] input_port_a_instr);
   c_c_read:    cover property (sector_done ##[1:20] input_port_c_instr);

endmodule : drpm_top

// *** hdl/drpm_pkg.sv ***
package drpm_pkg;

   // readback mode, gray along normal -> alt1 -> alt2
   typedef enum logic [1:0] {
      DRPM_NORMAL = 2'b00,
      DRPM_ALT1   = 2'b01,
      DRPM_ALT2   = 2'b11
   } drpm_mode_e;

   // codes that the host writes on the mode selector
   localparam logic [1:0]  SEL_NORMAL       = 2'h0;
   localparam logic [1:0]  SEL_ALT1         = 2'h1;
   localparam logic [1:0]  SEL_ALT2         = 2'h2;

   // bit 0 of the accumulator is the msb of the 16-bit word
   localparam int          XMA_LSB          = 0;
   localparam int          XMA_W            = 4;
   localparam int          SURF_LSB         = 10;
   localparam int          SURF_W           = 6;
   localparam int          SEC_LSB          = 5;
   localparam int          SEC_W            = 5;
   localparam int          CNT_LSB          = 0;
   localparam int          CNT_W            = 5;

   localparam logic [15:0] RST_WORD         = 16'h0000;
   localparam logic [31:0] RST_ECC          = 32'h0000_0000;
   localparam logic [5:0]  RST_SURF         = 6'h00;
   localparam logic [4:0]  RST_FIELD5       = 5'h00;
   localparam logic [3:0]  RST_XMA          = 4'h0;
   localparam int          WORDS_PER_SECTOR = 256;

endpackage : drpm_pkg

// *** hdl/drpm_ecc_if.sv ***
`timescale 1ns/100ps
interface drpm_ecc_if;
   logic        capture;
   logic [31:0] rem;
   logic [31:0] held;
   modport keeper (input capture, input rem, output held);
   modport user   (output capture, output rem, input held);
endinterface : drpm_ecc_if

// *** hdl/drpm_ecc_hold.sv ***
`timescale 1ns/100ps
module drpm_ecc_hold (
   input  wire logic   sys_clk,  // 200 mhz clock
   input  wire logic   rst_n,    // synchronised reset, active low
   drpm_ecc_if.keeper  ecc       // remainder capture and hold
);
   logic [31:0] rem_q;
   logic [31:0] rem_d;

   always_comb begin
      rem_d = rem_q;
      if (ecc.capture) begin
         rem_d = ecc.rem; // [R7]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rem_q <= drpm_pkg::RST_ECC;
      end else begin
         rem_q <= rem_d;
      end
   end

   assign ecc.held = rem_q;

   property p_ecc_kept;
      @(posedge sys_clk) disable iff (!rst_n)
      ecc.capture ##1 (!ecc.capture) [*3] |-> ecc.held == $past(ecc.rem, 3);
   endproperty
   a_ecc_kept: assert property (p_ecc_kept) // [R7]
      else $error("ecc remainder not held after capture");

endmodule : drpm_ecc_hold

// *** verification/drpm_host_model.sv ***
`timescale 1ns/100ps
module drpm_host_model (
   input  wire logic        sys_clk,            // bench clock
   input  wire logic [15:0] rd_data,            // word from the device
   input  wire logic        rd_valid,           // read data strobe
   output logic             mode_wr,            // mode selector write
   output logic [1:0]       mode_sel,           // mode selector code
   output logic             input_port_a_instr, // port A instruction
   output logic             input_port_b_instr, // port B instruction
   output logic             input_port_c_instr  // port C instruction
);
   initial begin
      mode_wr            = 1'b0;
      mode_sel           = 2'h0;
      input_port_a_instr = 1'b0;
      input_port_b_instr = 1'b0;
      input_port_c_instr = 1'b0;
   end

   // released code is inverted so a stale value is never reused
   task automatic set_mode(input logic [1:0] code);
      @(posedge sys_clk);
      mode_wr  <= 1'b1;
      mode_sel <= code;
      @(posedge sys_clk);
      mode_wr  <= 1'b0;
      mode_sel <= ~code;
      #1;
   endtask : set_mode

   // gap idle cycles first; address read after a non-ecc error is
   // never trusted by callers
   task automatic read_port(input int port, input int gap,
                            output logic [15:0] data,
                            output logic v_on, output logic v_off);
      repeat (gap) @(posedge sys_clk);
      @(posedge sys_clk);
      input_port_a_instr <= (port == 0);
      input_port_b_instr <= (port == 1);
      input_port_c_instr <= (port == 2);
      @(posedge sys_clk);
      input_port_a_instr <= 1'b0;
      input_port_b_instr <= 1'b0;
      input_port_c_instr <= 1'b0;
      #1;
      v_on = rd_valid;
      data = rd_data;
      @(posedge sys_clk);
      #1;
      v_off = rd_valid;
   endtask : read_port
endmodule : drpm_host_model

// *** verification/drpm_tb.sv ***
`timescale 1ns/100ps
module tb;
   localparam int WPS = 256;
   logic        sys_clk, rstn, mode_wr, rd_valid;
   logic        input_port_a_instr, input_port_b_instr, input_port_c_instr;
   logic        ma_load, xma_load, word_xfer, sector_done, ecc_err_end;
   logic        chs_load, ecc_capture;
   logic [1:0]  mode_sel, mode;
   logic [15:0] ctrl_status, drive_status, ma_wdata, rd_data;
   logic [3:0]  xma_wdata;
   logic [5:0]  surf_wdata;
   logic [4:0]  sec_wdata, cnt_wdata;
   logic [31:0] ecc_rem;
   logic [15:0] rd_data_m;
   int          mismatches;
   int          checks;

   drpm_top #(.MULTI_VARIANT(1'b0), .WORDS_PER_SECTOR(WPS)) dut (
      .sys_clk, .rstn, .mode_wr, .mode_sel, .input_port_a_instr,
      .input_port_b_instr, .input_port_c_instr, .ctrl_status,
      .drive_status, .ma_load, .ma_wdata, .xma_load, .xma_wdata,
      .word_xfer, .sector_done, .ecc_err_end, .chs_load, .surf_wdata,
      .sec_wdata, .cnt_wdata, .ecc_capture, .ecc_rem, .rd_data,
      .rd_valid, .mode);

   // six-bit surface variant on the same stimulus, read data only
   drpm_top #(.MULTI_VARIANT(1'b1), .WORDS_PER_SECTOR(WPS)) dut_multi (
      .sys_clk, .rstn, .mode_wr, .mode_sel, .input_port_a_instr,
      .input_port_b_instr, .input_port_c_instr, .ctrl_status,
      .drive_status, .ma_load, .ma_wdata, .xma_load, .xma_wdata,
      .word_xfer, .sector_done, .ecc_err_end, .chs_load, .surf_wdata,
      .sec_wdata, .cnt_wdata, .ecc_capture, .ecc_rem,
      .rd_data(rd_data_m), .rd_valid(), .mode());

   drpm_host_model host (
      .sys_clk, .rd_data, .rd_valid, .mode_wr, .mode_sel,
      .input_port_a_instr, .input_port_b_instr, .input_port_c_instr);

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick

   // one read, strobe of exactly one cycle, then the word
   task automatic rd(input int port, input logic [15:0] exp);
      logic [15:0] d;
      logic        v1;
      logic        v0;
      host.read_port(port, port, d, v1, v0);
      check({15'h0, v1}, 16'h0001);
      check({15'h0, v0}, 16'h0000);
      check(d, exp);
   endtask : rd

   task automatic t_reset;
      check({14'h0, mode}, 16'h0000);
      rd(2, 16'h0000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_normal;
      @(posedge sys_clk);
      ctrl_status  <= 16'h1234;
      drive_status <= 16'h8a5c;
      host.set_mode(drpm_pkg::SEL_NORMAL);
      rd(0, 16'h1234);
      rd(1, 16'h8a5c);
      $display("test normal done");
   endtask : t_normal

   task automatic t_alt1;
      host.set_mode(drpm_pkg::SEL_ALT1);
      check({14'h0, mode}, 16'h0001);
      @(posedge sys_clk);
      ma_load   <= 1'b1;
      ma_wdata  <= 16'hfffe;
      xma_load  <= 1'b1;
      xma_wdata <= 4'ha;
      tick(1);
      ma_load   <= 1'b0;
      xma_load  <= 1'b0;
      word_xfer <= 1'b1;
      tick(3);
      word_xfer <= 1'b0;
      rd(0, 16'h0001);
      rd(1, 16'h000a);
      check(rd_data_m, 16'h0000);
      $display("test alt1 done");
   endtask : t_alt1

   task automatic t_ecc_err;
      @(posedge sys_clk);
      ma_load     <= 1'b1;
      ma_wdata    <= 16'h2000;
      tick(1);
      ma_load     <= 1'b0;
      word_xfer   <= 1'b1;
      tick(3);
      word_xfer   <= 1'b0;
      sector_done <= 1'b1;
      tick(1);
      sector_done <= 1'b0;
      word_xfer   <= 1'b1;
      tick(7);
      word_xfer   <= 1'b0;
      ecc_err_end <= 1'b1;
      tick(1);
      ecc_err_end <= 1'b0;
      rd(0, 16'h2003 + WPS[15:0]);
      $display("test ecc error done");
   endtask : t_ecc_err

   task automatic t_alt2;
      logic [31:0] val [2];
      val = '{32'hdead_beef, 32'h0123_4567};
      host.set_mode(drpm_pkg::SEL_ALT2);
      check({14'h0, mode}, 16'h0003);
      host.set_mode(2'h3);
      check({14'h0, mode}, 16'h0003);
      foreach (val[i]) begin
         @(posedge sys_clk);
         ecc_capture <= 1'b1;
         ecc_rem     <= val[i];
         tick(1);
         ecc_capture <= 1'b0;
         rd(0, val[i][31:16]);
         rd(1, val[i][15:0]);
      end
      $display("test alt2 done");
   endtask : t_alt2

   task automatic t_portc;
      @(posedge sys_clk);
      chs_load    <= 1'b1;
      surf_wdata  <= 6'h2b;
      sec_wdata   <= 5'h15;
      cnt_wdata   <= 5'h1d;
      tick(1);
      chs_load    <= 1'b0;
      rd(2, {1'b0, 5'h0b, 5'h15, 5'h1d});
      check(rd_data_m, {6'h2b, 5'h15, 5'h1d});
      @(posedge sys_clk);
      sector_done <= 1'b1;
      tick(3);
      sector_done <= 1'b0;
      rd(2, {1'b0, 5'h0b, 5'h18, 5'h00});
      check(rd_data_m, {6'h2b, 5'h18, 5'h00});
      $display("test port c done");
   endtask : t_portc

   initial begin
      #100000;
      mismatches++;
      tally_and_finish;
   end

   initial begin
      mismatches = 0;
      checks     = 0;
      rstn       = 1'b0;
      {ma_load, xma_load, word_xfer, sector_done} = 4'h0;
      {ecc_err_end, chs_load, ecc_capture} = 3'h0;
      {ctrl_status, drive_status, ma_wdata} = 48'h0;
      {xma_wdata, surf_wdata, sec_wdata, cnt_wdata} = 20'h0;
      ecc_rem    = 32'h0;
      tick(16);
      rstn <= 1'b1;
      tick(4);
      t_reset;
      t_normal;
      t_alt1;
      t_ecc_err;
      t_alt2;
      t_portc;
      tally_and_finish;
   end
endmodule : tb
